// ===== logic/dst_timers.sv
// dual sixteen bit timers x and y with apb register access
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps
module dst_timers
  import dst_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input wire logic mclk, // 250 mhz clock
  input wire logic arst_n, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic sub_clock_in, // sub clock pin
  input wire logic trigger_in, // power switch trigger pin
  input wire logic stop_in_a, // output stop pin a
  input wire logic stop_in_b, // output stop pin b
  input wire logic event_in_x, // timer x event pin
  input wire logic event_in_y, // timer y event pin
  input wire logic timer1_uflow, // timer 1 underflow pulse, same clock
  output logic pulse_out_x, // timer x output pin
  output logic irq_x_ff, // timer x request level
  output logic irq_y_ff // timer y request level
);
  ////////////////////////////////////////////////////////////////
  logic [2:0] sub_sync_ff, trg_sync_ff, sa_sync_ff, sb_sync_ff, ex_sync_ff, ey_sync_ff;
  logic [17:0] tx_cnt_ff, tx_latch_ff;
  logic [15:0] cmp_ff, cmp_pend_ff, ty_cnt_ff, ty_latch_ff, ty_cap_ff;
  logic [15:0] txm_ff, txc_ff, tym_ff;
  logic [3:0] st_ff;
  logic [7:0] tx_hi_rd_ff, ty_lo_rd_ff;
  logic [1:0] tx_ext_rd_ff;
  logic ty_cap_vld_ff, win_ff, hi_pend_ff;
  logic [DIV_W-1:0] divx_ff, divy_ff;
  logic [TRIG_FILT_LEN-1:0] trg_hist_ff;
  logic trg_filt_ff;
  logic [3:0] trg_dly_ff;
  logic trg_dly_act_ff;
  dst_psst_e ps_ff;
  logic wr, rd, tick_x, tick_y, src_x, src_y, uf_x, uf_y, tx_run, hi_wr_x, evy_edge;
  logic ext_on, evx_edge, trg_edge, trg_fire, stop_evt;
  logic [3:0] dly_sel;
  dst_txmode_e txmode;
  dst_tymode_e tymode;

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign txmode = dst_txmode_e'(txm_ff[TXM_MODE_LSB +: 3]);
  assign tymode = dst_tymode_e'(tym_ff[TYM_MODE_LSB +: 2]);

  ////////////////////////////////////////////////////////////////
  // two-stage synchronisers plus a third stage for edge detection
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sub_sync_ff <= 3'h0;
      trg_sync_ff <= 3'h0;
      sa_sync_ff <= 3'h0;
      sb_sync_ff <= 3'h0;
      ex_sync_ff <= 3'h0;
      ey_sync_ff <= 3'h0;
    end else begin
      sub_sync_ff <= {sub_sync_ff[1:0], sub_clock_in};
      trg_sync_ff <= {trg_sync_ff[1:0], trigger_in};
      sa_sync_ff <= {sa_sync_ff[1:0], stop_in_a};
      sb_sync_ff <= {sb_sync_ff[1:0], stop_in_b};
      ex_sync_ff <= {ex_sync_ff[1:0], event_in_x};
      ey_sync_ff <= {ey_sync_ff[1:0], event_in_y};
    end
  end

  // rising edge of the sub clock pin counts whether oscillating or driven externally
  assign src_x = txm_ff[TXM_SUBCLK] ? (sub_sync_ff[1] & ~sub_sync_ff[2]) : 1'b1;
  assign src_y = tym_ff[TYM_SUBCLK] ? (sub_sync_ff[1] & ~sub_sync_ff[2]) : 1'b1;

  // count-source dividers, ratios 1, 2, 16, 32, 64, 128, 256 and 1024 mapped onto fixed taps
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      divx_ff <= '0;
      divy_ff <= '0;
    end else begin
      if (src_x) divx_ff <= divx_ff + 1'b1;
      if (src_y) divy_ff <= divy_ff + 1'b1;
    end
  end

  function automatic logic div_tick(input logic [2:0] sel, input logic [DIV_W-1:0] d, input logic src);
    logic [DIV_W-1:0] m;
    m = '0;
    unique case (sel)
      3'h0: m = '0;
      3'h1: m = DIV_W'(1);
      3'h2: m = DIV_W'(15);
      3'h3: m = DIV_W'(31);
      3'h4: m = DIV_W'(63);
      3'h5: m = DIV_W'(127);
      3'h6: m = DIV_W'(255);
      3'h7: m = DIV_W'(1023);
    endcase
    div_tick = src & ((d & m) == m);
  endfunction

  ////////////////////////////////////////////////////////////////
  // event edges; edge select doubles as interrupt edge
  assign evx_edge = txc_ff[TXC_EVT_EDGE6] ? (~ex_sync_ff[1] & ex_sync_ff[2])
                                          : (ex_sync_ff[1] & ~ex_sync_ff[2]);
  assign evy_edge = (tymode == DST_TY_HL) ? (ey_sync_ff[1] ^ ey_sync_ff[2]) :
                    tym_ff[TYM_EDGE] ? (~ey_sync_ff[1] & ey_sync_ff[2]) : (ey_sync_ff[1] & ~ey_sync_ff[2]);

  // trigger noise filter: four equal samples
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trg_hist_ff <= '0;
      trg_filt_ff <= 1'b0;
    end else begin
      trg_hist_ff <= {trg_hist_ff[TRIG_FILT_LEN-2:0], trg_sync_ff[1]};
      if (&trg_hist_ff) trg_filt_ff <= 1'b1;
      else if (~|trg_hist_ff) trg_filt_ff <= 1'b0;
    end
  end
  assign trg_edge = txc_ff[TXC_TRIG_FALL] ? (~trg_hist_ff[0] & trg_filt_ff & ~|trg_hist_ff)
                                          : (trg_hist_ff[0] & ~trg_filt_ff & &trg_hist_ff);

  // trigger delay, one of four values
  always_comb begin
    dly_sel = TRIG_DLY0;
    unique case (txc_ff[TXC_DELAY_LSB +: 2])
      2'h0: dly_sel = TRIG_DLY0;
      2'h1: dly_sel = TRIG_DLY1;
      2'h2: dly_sel = TRIG_DLY2;
      2'h3: dly_sel = TRIG_DLY3;
    endcase
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trg_dly_ff <= 4'h0;
      trg_dly_act_ff <= 1'b0;
    end else if (trg_edge) begin
      trg_dly_ff <= dly_sel;
      trg_dly_act_ff <= 1'b1;
    end else if (trg_dly_act_ff && trg_dly_ff != 4'h0) begin
      trg_dly_ff <= trg_dly_ff - 4'h1;
    end else begin
      trg_dly_act_ff <= 1'b0;
    end
  end
  assign trg_fire = trg_dly_act_ff && trg_dly_ff == 4'h0;
  assign stop_evt = (txmode == DST_TX_PSW) &&
                    ((txc_ff[TXC_OUTCTL1] && sa_sync_ff[1] != sa_sync_ff[2]) ||
                     (txc_ff[TXC_OUTCTL2] && sb_sync_ff[1] != sb_sync_ff[2]));

  ////////////////////////////////////////////////////////////////
  // power-switch sequence: dummy output, then wait trigger, then run
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) ps_ff <= DST_PS_IDLE;
    else if (txmode != DST_TX_PSW) ps_ff <= DST_PS_IDLE;
    else if (!txm_ff[TXM_STOP]) begin // stop holds the phase so the output stays frozen
      unique case (ps_ff)
        DST_PS_IDLE: ps_ff <= DST_PS_WAIT;
        DST_PS_WAIT: if (trg_fire) ps_ff <= DST_PS_RUN;
        DST_PS_RUN: ps_ff <= DST_PS_RUN;
      endcase
    end
  end

  // event window gated by timer 1 underflow
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) win_ff <= 1'b1;
    else if (timer1_uflow) win_ff <= ~txm_ff[TXM_WINDOW];
  end

  ////////////////////////////////////////////////////////////////
  // timer x count tick per mode
  always_comb begin
    tick_x = 1'b0;
    unique case (txmode)
      DST_TX_EVENT: tick_x = evx_edge & win_ff;
      DST_TX_WIDTH: tick_x = div_tick(txm_ff[TXM_DIV_LSB +: 3], divx_ff, src_x) &
                             (ex_sync_ff[2] ^ txc_ff[TXC_EVT_EDGE6]);
      DST_TX_PSW: tick_x = div_tick(txm_ff[TXM_DIV_LSB +: 3], divx_ff, src_x) & (ps_ff == DST_PS_RUN);
      default: tick_x = div_tick(txm_ff[TXM_DIV_LSB +: 3], divx_ff, src_x);
    endcase
  end
  assign ext_on = (txmode != DST_TX_PSW) && (txmode != DST_TX_PWM);
  assign tx_run = tick_x & ~txm_ff[TXM_STOP];
  assign uf_x = tx_run && (ext_on ? tx_cnt_ff == 18'h0 : tx_cnt_ff[15:0] == 16'h0);
  assign hi_wr_x = wr && paddr == ADDR_TX_HI;

  // timer x counter and reload latch; ext bits form msbs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_cnt_ff <= {EXT_RESET, TX_RESET};
      tx_latch_ff <= {EXT_RESET, TX_RESET};
      hi_pend_ff <= 1'b0;
    end else begin
      if (wr && paddr == ADDR_TX_EXT) tx_latch_ff[17:16] <= pwdata[1:0];
      if (wr && paddr == ADDR_TX_LO) tx_latch_ff[7:0] <= pwdata[7:0];
      if (hi_wr_x) begin
        tx_latch_ff[15:8] <= pwdata[7:0];
        if (!txm_ff[TXM_LATCH_ONLY] || uf_x)
          tx_cnt_ff <= {tx_latch_ff[17:16], pwdata[7:0], tx_latch_ff[7:0]};
        hi_pend_ff <= txm_ff[TXM_LATCH_ONLY] & ~uf_x;
      end else if (uf_x) begin
        tx_cnt_ff <= ext_on ? tx_latch_ff : {2'h0, tx_latch_ff[15:0]};
        hi_pend_ff <= 1'b0;
      end else if (tx_run) begin
        tx_cnt_ff <= tx_cnt_ff - 18'h1;
      end
    end
  end

  // compare staged; applied at once, or with the pending timer value at underflow when latch-only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_ff <= CMP_RESET;
      cmp_pend_ff <= CMP_RESET;
    end else begin
      if (wr && paddr == ADDR_CMP_LO) cmp_pend_ff[7:0] <= pwdata[7:0];
      if (wr && paddr == ADDR_CMP_HI) cmp_pend_ff[15:8] <= pwdata[7:0];
      if (!txm_ff[TXM_LATCH_ONLY] || (uf_x && hi_pend_ff)) cmp_ff <= cmp_pend_ff;
    end
  end

  // timer x output pin
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) pulse_out_x <= 1'b0;
    else begin
      unique case (txmode)
        DST_TX_PULSE: if (uf_x) pulse_out_x <= ~pulse_out_x;
        DST_TX_PSW, DST_TX_PWM: begin
          if (txmode == DST_TX_PSW && ps_ff == DST_PS_IDLE) pulse_out_x <= ~txc_ff[TXC_EDGE_SW];
          else if (txm_ff[TXM_STOP]) pulse_out_x <= pulse_out_x;
          else if (uf_x || (txmode == DST_TX_PSW && ps_ff == DST_PS_WAIT && trg_fire))
            pulse_out_x <= ~txc_ff[TXC_EDGE_SW];
          else if (tick_x && tx_cnt_ff[15:0] == cmp_ff) pulse_out_x <= txc_ff[TXC_EDGE_SW];
        end
        default: pulse_out_x <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // timer y tick, underflow, edge reload and capture
  assign tick_y = (tymode == DST_TY_EVENT) ? evy_edge
                                           : div_tick(tym_ff[TYM_DIV_LSB +: 3], divy_ff, src_y);
  assign uf_y = tick_y && !tym_ff[TYM_STOP] && ty_cnt_ff == 16'h0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ty_cnt_ff <= TY_RESET;
      ty_latch_ff <= TY_RESET;
      ty_cap_ff <= TY_RESET;
      ty_cap_vld_ff <= 1'b0;
    end else begin
      if (wr && paddr == ADDR_TY_LO) ty_latch_ff[7:0] <= pwdata[7:0];
      if (wr && paddr == ADDR_TY_HI) begin
        ty_latch_ff[15:8] <= pwdata[7:0];
        if (!tym_ff[TYM_LATCH_ONLY] || uf_y) ty_cnt_ff <= {pwdata[7:0], ty_latch_ff[7:0]};
      end else if ((tymode == DST_TY_PERIOD || tymode == DST_TY_HL) && evy_edge) begin
        ty_cnt_ff <= ty_latch_ff;
      end else if (uf_y) begin
        ty_cnt_ff <= ty_latch_ff;
      end else if (tick_y && !tym_ff[TYM_STOP]) begin
        ty_cnt_ff <= ty_cnt_ff - 16'h1;
      end
      // capture held until one full read
      if ((tymode == DST_TY_PERIOD || tymode == DST_TY_HL) && evy_edge) begin
        ty_cap_ff <= ty_cnt_ff;
        ty_cap_vld_ff <= 1'b1;
      end else if (rd && paddr == ADDR_TY_LO) ty_cap_vld_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // request flags; hardware set beats software clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) st_ff <= 4'h0;
    else begin
      for (int i = 0; i < 4; i++) begin
        if (wr && paddr == ADDR_STATUS && pwdata[i]) st_ff[i] <= 1'b0;
      end
      if (uf_x) st_ff[ST_TX_REQ] <= 1'b1;
      if (uf_y || ((tymode == DST_TY_PERIOD || tymode == DST_TY_HL) && evy_edge))
        st_ff[ST_TY_REQ] <= 1'b1;
      if (evx_edge) st_ff[ST_EVX_REQ] <= 1'b1;
      if (evy_edge) st_ff[ST_EVY_REQ] <= 1'b1;
    end
  end

  // mode and control registers; stop inputs force the stop bit in power-switch mode
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txm_ff <= 16'h0;
      txc_ff <= 16'h0;
      tym_ff <= 16'h0;
    end else begin
      if (wr && paddr == ADDR_TX_MODE) txm_ff <= pwdata[15:0];
      if (wr && paddr == ADDR_TX_CTRL) txc_ff <= pwdata[15:0];
      if (wr && paddr == ADDR_TY_MODE) tym_ff <= pwdata[15:0];
      if (stop_evt) txm_ff[TXM_STOP] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb read path with high-first latching of low bytes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      tx_hi_rd_ff <= 8'h0;
      tx_ext_rd_ff <= 2'h0;
      ty_lo_rd_ff <= 8'h0;
      irq_x_ff <= 1'b0;
      irq_y_ff <= 1'b0;
    end else begin
      irq_x_ff <= st_ff[ST_TX_REQ] | st_ff[ST_EVX_REQ];
      irq_y_ff <= st_ff[ST_TY_REQ] | st_ff[ST_EVY_REQ];
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0;
        pslverr <= paddr > ADDR_STATUS || paddr[1:0] != 2'h0;
        if (!pwrite) begin
          unique case (paddr)
            ADDR_TX_EXT: begin
              prdata <= {30'h0, tx_cnt_ff[17:16]};
              tx_ext_rd_ff <= tx_cnt_ff[17:16];
            end
            ADDR_TX_HI: begin
              prdata <= {24'h0, tx_cnt_ff[15:8]};
              tx_hi_rd_ff <= tx_cnt_ff[7:0];
            end
            ADDR_TX_LO: prdata <= {24'h0, tx_hi_rd_ff};
            ADDR_CMP_LO: prdata <= {24'h0, cmp_pend_ff[7:0]};
            ADDR_CMP_HI: prdata <= {24'h0, cmp_pend_ff[15:8]};
            ADDR_TX_MODE: prdata <= {16'h0, txm_ff};
            ADDR_TX_CTRL: prdata <= {16'h0, txc_ff};
            ADDR_TY_HI: begin
              prdata <= {24'h0, ty_cap_vld_ff ? ty_cap_ff[15:8] : ty_cnt_ff[15:8]};
              ty_lo_rd_ff <= ty_cap_vld_ff ? ty_cap_ff[7:0] : ty_cnt_ff[7:0];
            end
            ADDR_TY_LO: prdata <= {24'h0, ty_lo_rd_ff};
            ADDR_TY_MODE: prdata <= {16'h0, tym_ff};
            ADDR_STATUS: prdata <= {28'h0, st_ff};
            default: prdata <= 32'h0;
          endcase
        end
      end
    end
  end
endmodule : dst_timers

// ===== logic/dst_pkg.sv
// package for the dual sixteen bit timers block
package dst_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_TX_LO = 8'h00;
  localparam logic [7:0] ADDR_TX_HI = 8'h04;
  localparam logic [7:0] ADDR_TX_EXT = 8'h08;
  localparam logic [7:0] ADDR_CMP_LO = 8'h0c;
  localparam logic [7:0] ADDR_CMP_HI = 8'h10;
  localparam logic [7:0] ADDR_TX_MODE = 8'h14;
  localparam logic [7:0] ADDR_TX_CTRL = 8'h18;
  localparam logic [7:0] ADDR_TY_LO = 8'h1c;
  localparam logic [7:0] ADDR_TY_HI = 8'h20;
  localparam logic [7:0] ADDR_TY_MODE = 8'h24;
  localparam logic [7:0] ADDR_STATUS = 8'h28;
  // timer x mode register fields
  localparam int TXM_MODE_LSB = 0;
  localparam int TXM_LATCH_ONLY = 3;
  localparam int TXM_SUBCLK = 4;
  localparam int TXM_WINDOW = 5;
  localparam int TXM_STOP = 7;
  localparam int TXM_DIV_LSB = 8;
  // timer x control register fields
  localparam int TXC_EDGE_SW = 0;
  localparam int TXC_OUTCTL1 = 1;
  localparam int TXC_OUTCTL2 = 2;
  localparam int TXC_DELAY_LSB = 3;
  localparam int TXC_TRIG_FALL = 5;
  localparam int TXC_EVT_EDGE6 = 6;
  localparam int TXC_EVT_EDGE7 = 7;
  // timer y mode register fields
  localparam int TYM_MODE_LSB = 0;
  localparam int TYM_EDGE = 2;
  localparam int TYM_SUBCLK = 3;
  localparam int TYM_LATCH_ONLY = 4;
  localparam int TYM_STOP = 7;
  localparam int TYM_DIV_LSB = 8;
  // status register fields (write one to clear)
  localparam int ST_TX_REQ = 0;
  localparam int ST_TY_REQ = 1;
  localparam int ST_EVX_REQ = 2;
  localparam int ST_EVY_REQ = 3;
  // reset values
  localparam logic [15:0] TX_RESET = 16'hffff;
  localparam logic [15:0] TY_RESET = 16'hffff;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [1:0] EXT_RESET = 2'h0;
  // trigger filter length in sampling clocks
  localparam int TRIG_FILT_LEN = 4;
  // trigger delay choices in mclk cycles
  localparam logic [3:0] TRIG_DLY0 = 4'h0;
  localparam logic [3:0] TRIG_DLY1 = 4'h2;
  localparam logic [3:0] TRIG_DLY2 = 4'h4;
  localparam logic [3:0] TRIG_DLY3 = 4'h8;
  // timer x modes
  typedef enum logic [2:0] {
    DST_TX_TIMER = 3'h0, DST_TX_PULSE = 3'h1, DST_TX_PSW = 3'h2,
    DST_TX_PWM = 3'h3, DST_TX_EVENT = 3'h4, DST_TX_WIDTH = 3'h5
  } dst_txmode_e;
  // timer y modes
  typedef enum logic [1:0] {
    DST_TY_TIMER = 2'h0, DST_TY_PERIOD = 2'h1, DST_TY_EVENT = 2'h2, DST_TY_HL = 2'h3
  } dst_tymode_e;
  // power-switch sequencing, one-hot
  typedef enum logic [2:0] {
    DST_PS_IDLE = 3'b001, DST_PS_WAIT = 3'b010, DST_PS_RUN = 3'b100
  } dst_psst_e;
endpackage : dst_pkg

// ===== verification/dst_pin_src.sv
// external pin source model for the dual timers
`timescale 1ns/100ps
module dst_pin_src (
  input wire logic mclk, // bench clock
  output logic event_in_x, // timer x event pin
  output logic event_in_y, // timer y event pin
  output logic trigger_in, // trigger pin
  output logic stop_in_a, // stop pin a
  output logic stop_in_b, // stop pin b
  output logic sub_clock_in, // sub clock pin, oscillator stopped
  output logic timer1_uflow // timer 1 underflow pulse
);
  logic [6:0] pin_ff;
  ////////////////////////////////////////////////////////////////
  // all pins idle low
  initial pin_ff = 7'h00;
  assign {timer1_uflow, sub_clock_in, stop_in_b, stop_in_a, trigger_in, event_in_y, event_in_x} = pin_ff;
  // change one pin just after an edge
  task automatic drive(input int sel, input logic v);
    @(posedge mclk);
    pin_ff[sel] <= v;
  endtask : drive
  // slow pulses so the two-flop synchroniser sees every level
  task automatic pulses(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      drive(sel, 1'b1);
      repeat (3) @(posedge mclk);
      drive(sel, 1'b0);
      repeat (3) @(posedge mclk);
    end
  endtask : pulses
endmodule : dst_pin_src

// ===== verification/dst_timers_checker.sv
// port checker for the dual timers block
`timescale 1ns/100ps
module dst_timers_checker
  import dst_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input wire logic mclk, // clock
  input wire logic arst_n, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic stop_in_a, // stop pin a
  input wire logic pulse_out_x, // timer x output
  input wire logic irq_x_ff, // timer x request
  input wire logic irq_y_ff // timer y request
);
  logic [2:0] mode_ff;
  logic ctl1_ff;
  logic clr1_ff;
  logic clr2_ff;
  wire logic wr_acc = psel & penable & pwrite;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////
  // shadow of mode, stop enable and status clears
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= 3'h0;
      ctl1_ff <= 1'b0;
      clr1_ff <= 1'b0;
      clr2_ff <= 1'b0;
    end else begin
      if (wr_acc && paddr == ADDR_TX_MODE) mode_ff <= pwdata[2:0];
      if (wr_acc && paddr == ADDR_TX_CTRL) ctl1_ff <= pwdata[TXC_OUTCTL1];
      clr1_ff <= wr_acc && paddr == ADDR_STATUS && (pwdata[ST_TX_REQ] || pwdata[ST_EVX_REQ]);
      clr2_ff <= clr1_ff;
    end
  end
  ////////////////////////////////////////////////////////////////
  ready_setup_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
  err_unmapped_a: assert property (psel && !penable && (paddr > ADDR_STATUS || paddr[1:0] != 2'h0)
    |=> pslverr && pready) else $error("unmapped not refused");
  err_mapped_a: assert property (psel && !penable && paddr <= ADDR_STATUS && paddr[1:0] == 2'h0
    |=> !pslverr) else $error("mapped refused");
  reset_quiet_a: assert property ($rose(arst_n) |-> !pulse_out_x && !irq_x_ff && !irq_y_ff)
    else $error("outputs busy after reset");
  irq_clear_a: assert property ($fell(irq_x_ff) |-> clr1_ff || clr2_ff) else $error("x request lost");
  timer_quiet_a: assert property (mode_ff == DST_TX_TIMER && $past(mode_ff) == DST_TX_TIMER
    && $past(mode_ff, 2) == DST_TX_TIMER |-> $stable(pulse_out_x)) else $error("output moved in timer mode");
  pulse_irq_a: assert property (mode_ff == DST_TX_PULSE && $changed(pulse_out_x)
    |-> ##[0:2] irq_x_ff) else $error("toggle without underflow");
  stop_freeze_a: assert property (mode_ff == DST_TX_PSW && ctl1_ff && $changed(stop_in_a)
    |-> ##6 $stable(pulse_out_x) [*8]) else $error("output not frozen");
  // main scenarios
  cover property (mode_ff == DST_TX_PULSE && $changed(pulse_out_x));
  cover property (pslverr);
  cover property ($rose(irq_y_ff));
endmodule : dst_timers_checker
bind dst_timers dst_timers_checker #(.DIV_W(DIV_W)) dst_timers_checker_i (.mclk(mclk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .stop_in_a(stop_in_a), .pulse_out_x(pulse_out_x), .irq_x_ff(irq_x_ff),
  .irq_y_ff(irq_y_ff));

// ===== verification/testbench.sv
// self-checking bench for the dual timers block
`timescale 1ns/100ps
module testbench import dst_pkg::*;;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic event_in_x, event_in_y, trigger_in, stop_in_a, stop_in_b, sub_clock_in, timer1_uflow;
  logic pulse_out_x, irq_x_ff, irq_y_ff;
  logic [15:0] v;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  ////////////////////////////////////////////////////////////////
  // clock and time-zero inputs
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  initial {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
  dst_timers #(.DIV_W(10)) dst_timers_i (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sub_clock_in(sub_clock_in), .trigger_in(trigger_in), .stop_in_a(stop_in_a), .stop_in_b(stop_in_b),
    .event_in_x(event_in_x), .event_in_y(event_in_y), .timer1_uflow(timer1_uflow),
    .pulse_out_x(pulse_out_x), .irq_x_ff(irq_x_ff), .irq_y_ff(irq_y_ff));
  dst_pin_src dst_pin_src_i (.mclk(mclk), .event_in_x(event_in_x), .event_in_y(event_in_y),
    .trigger_in(trigger_in), .stop_in_a(stop_in_a), .stop_in_b(stop_in_b), .sub_clock_in(sub_clock_in),
    .timer1_uflow(timer1_uflow));
  ////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // sixteen-bit access: high byte read first, low byte written first
  task automatic rd16(input logic [7:0] hi, input logic [7:0] lo);
    rd(hi);
    v[15:8] = q[7:0];
    rd(lo);
    v[7:0] = q[7:0];
  endtask : rd16
  task automatic ld16(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] d);
    wr(lo, {24'h0, d[7:0]});
    wr(hi, {24'h0, d[15:8]});
  endtask : ld16
  // cycles until the output toggles
  task automatic waittog();
    logic p;
    p = pulse_out_x;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pulse_out_x === p && n < 100);
  endtask : waittog
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask : tend
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    rd(ADDR_TX_EXT); chk("ext reset", {30'h0, EXT_RESET}, {30'h0, q[1:0]});
    rd(ADDR_CMP_LO); chk("cmp lo reset", {24'h0, CMP_RESET[7:0]}, {24'h0, q[7:0]});
    rd(ADDR_CMP_HI); chk("cmp hi reset", {24'h0, CMP_RESET[15:8]}, {24'h0, q[7:0]});
    rd(8'h2c); chk("err 2c", 1, e);
    rd(8'h01); chk("err 01", 1, e);
    rd(ADDR_STATUS); chk("err 28", 0, e);
    tend("reset and decode");
    wr(ADDR_TX_MODE, 32'h80);
    wr(ADDR_TX_EXT, 0); ld16(ADDR_TX_HI, ADDR_TX_LO, 16'h1234);
    rd16(ADDR_TX_HI, ADDR_TX_LO); chk("tx direct", 16'h1234, v);
    wr(ADDR_TX_MODE, 32'h88);
    wr(ADDR_TX_EXT, 0); ld16(ADDR_TX_HI, ADDR_TX_LO, 16'h0055);
    rd16(ADDR_TX_HI, ADDR_TX_LO); chk("tx latch only", 16'h1234, v);
    wr(ADDR_TX_MODE, 32'h80);
    wr(ADDR_TX_EXT, 1); ld16(ADDR_TX_HI, ADDR_TX_LO, 16'h0000);
    rd(ADDR_TX_EXT); chk("tx ext", 1, {30'h0, q[1:0]});
    rd16(ADDR_TX_HI, ADDR_TX_LO); chk("tx wide low", 0, v);
    tend("timer x load");
    wr(ADDR_TX_MODE, 32'h81);
    wr(ADDR_TX_EXT, 0); ld16(ADDR_TX_HI, ADDR_TX_LO, 16'h0002);
    wr(ADDR_STATUS, 32'hf);
    wr(ADDR_TX_MODE, 32'h01);
    waittog();
    waittog(); chk("pulse period", 3, n);
    wr(ADDR_TX_MODE, 32'h81);
    rd(ADDR_STATUS); chk("tx request", 1, q[ST_TX_REQ]);
    wr(ADDR_STATUS, 32'h1);
    repeat (3) @(posedge mclk);
    chk("irq x clear", 0, irq_x_ff);
    tend("pulse output");
    wr(ADDR_TX_MODE, 32'h85);
    wr(ADDR_TX_EXT, 0); ld16(ADDR_TX_HI, ADDR_TX_LO, 16'h0100);
    wr(ADDR_TX_CTRL, 0);
    wr(ADDR_TX_MODE, 32'h05);
    repeat (20) @(posedge mclk);
    wr(ADDR_TX_MODE, 32'h85);
    rd16(ADDR_TX_HI, ADDR_TX_LO); chk("width high only", 16'h0100, v);
    wr(ADDR_TX_CTRL, 32'h40);
    wr(ADDR_TX_MODE, 32'h05);
    repeat (20) @(posedge mclk);
    wr(ADDR_TX_MODE, 32'h85);
    rd16(ADDR_TX_HI, ADDR_TX_LO); chk("width low", 1, v < 16'h0100);
    tend("width");
    wr(ADDR_TX_MODE, 32'h84);
    wr(ADDR_TX_EXT, 0); ld16(ADDR_TX_HI, ADDR_TX_LO, 16'h0100);
    wr(ADDR_TX_CTRL, 0);
    wr(ADDR_TX_MODE, 32'h04);
    dst_pin_src_i.pulses(0, 4);
    rd16(ADDR_TX_HI, ADDR_TX_LO); chk("event x", 16'h00fc, v);
    wr(ADDR_TX_MODE, 32'h24);
    dst_pin_src_i.drive(6, 1'b1);
    dst_pin_src_i.drive(6, 1'b0);
    dst_pin_src_i.pulses(0, 3);
    rd16(ADDR_TX_HI, ADDR_TX_LO); chk("event window", 16'h00fc, v);
    tend("event x");
    wr(ADDR_TY_MODE, 32'h02);
    ld16(ADDR_TY_HI, ADDR_TY_LO, 16'h0010);
    dst_pin_src_i.pulses(1, 5);
    rd16(ADDR_TY_HI, ADDR_TY_LO); chk("event y", 16'h000b, v);
    wr(ADDR_TY_MODE, 32'h01);
    ld16(ADDR_TY_HI, ADDR_TY_LO, 16'h1000);
    wr(ADDR_STATUS, 32'hf);
    dst_pin_src_i.pulses(1, 1);
    chk("irq y", 1, irq_y_ff);
    rd16(ADDR_TY_HI, ADDR_TY_LO); chk("period capture", 8'h0f, v[15:8]);
    wr(ADDR_TY_MODE, 32'h88);
    ld16(ADDR_TY_HI, ADDR_TY_LO, 16'h0010);
    wr(ADDR_TY_MODE, 32'h08);
    dst_pin_src_i.pulses(5, 4);
    wr(ADDR_TY_MODE, 32'h88);
    rd16(ADDR_TY_HI, ADDR_TY_LO); chk("sub clock y", 16'h000c, v);
    tend("timer y");
    wr(ADDR_TX_CTRL, 32'h02);
    wr(ADDR_TX_MODE, 32'h0a);
    dst_pin_src_i.drive(3, 1'b1);
    repeat (10) @(posedge mclk);
    rd(ADDR_TX_MODE); chk("stop forced", 1, q[TXM_STOP]);
    tend("stop input");
    wrap_up();
  end
endmodule : testbench
